// ==== src/rhp_pkg.sv ====
// constants and types shared by both ends of the reader host command port
// Summary of operation
// - all pins low at enable rise: parallel
// - interface type fixed during operation
// - serial straps: bit1 high, bit0 low
// - device is slave; host starts everything
// - interrupt output present in both types
// - serial pins: clock, mosi7, miso6, select4
// - direct mode: bit3 modulation, bits6/5 subcarrier
// - direct mode: bit2 receiver enable input
// - start then one eight-bit head word
// - burst ends burst stop; others single stop
// - head msb: 0 address, 1 command
// - bit6 read, bit5 burst, bits4-0 code
// - data words follow an address word
// - burst: address increments per data word
// - single: exactly one data word
// - host prefers burst for multi-byte access
// - command word triggers a device action
// - bit7 rise/fall, clock high: start/stop
// - bit7 rise-fall, clock low: burst stop
// - serial: sample falling, launch rising edges
// - serial words eight bits, msb first
package rhp_pkg;
    localparam int WORD_W     = 8;
    localparam int CODE_W     = 5;
    localparam int CMD_BIT    = 7;
    localparam int RW_BIT     = 6;
    localparam int CONT_BIT   = 5;
    localparam int P_MOSI     = 7;
    localparam int P_MISO     = 6;
    localparam int P_SS       = 4;
    localparam int P_MOD      = 3;
    localparam int P_RXEN     = 2;
    localparam int P_STRAP_HI = 1;
    localparam int P_STRAP_LO = 0;
    localparam int SYNC_W     = 11;
    localparam int CLK_NS     = 10;
    localparam int T_HALF_NS  = 150;
    localparam int HALF_CYC   = (T_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] PIN_NONE  = 8'h00;
    localparam logic [7:0] PIN_ALL   = 8'hFF;
    localparam logic [7:0] PAR_MARK  = 8'h80;
    localparam logic [7:0] SER_STRAP = 8'h12;
    localparam logic [7:0] SER_OE    = 8'h93;
    localparam logic [7:0] SUB_OE    = 8'h60;
    localparam logic [7:0] MISO_OE   = 8'h40;
    typedef enum logic [2:0] {OP_START, OP_WRITE, OP_READ, OP_STOP_SGL, OP_STOP_BURST} rhp_op_t;
    typedef enum logic [1:0] {FR_IDLE, FR_HEAD, FR_DATA} rhp_frame_t;
    typedef enum logic {HS_IDLE, HS_RUN} rhp_hstate_t;
endpackage : rhp_pkg

// ==== src/rhp_if.sv ====
// link between the host end and the reader end, with pin resolution
interface rhp_if;
    logic       link_clk;
    logic       en;
    logic [7:0] host_o;
    logic [7:0] host_oe;
    logic [7:0] dev_o;
    logic [7:0] dev_oe;
    logic [7:0] pins;
    logic       irq;
    // undriven pins read low
    assign pins = (dev_o & dev_oe) | (host_o & host_oe & ~dev_oe);
    modport dev  (input link_clk, en, pins, output dev_o, dev_oe, irq);
    modport host (output link_clk, en, host_o, host_oe, input pins, irq);
endinterface : rhp_if

// ==== src/rhp_sync.sv ====
// three-stage input synchroniser; a change counts once stages two and three agree
module rhp_sync #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_reg, s2_reg, s3_reg, q_next;

    always_comb
    begin
        q_next = (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & q);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            q      <= '0;
        end
        else if (ce)
        begin
            s1_reg <= d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            q      <= q_next;
        end
    end
endmodule : rhp_sync

// ==== src/rhp_reader_end.sv ====
// reader end: interface selection, framing, word decode and serial shifter
module rhp_reader_end (
    // core clock domain
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    // link to the host
    rhp_if.dev               link,
    // register access
    output logic [4:0]       reg_addr,
    output logic [7:0]       reg_wdata,
    output logic             reg_we,
    output logic             reg_re,
    input  wire logic [7:0]  reg_rdata,
    // commands and status
    output logic [4:0]       cmd_code,
    output logic             cmd_valid,
    output logic             frame_err,
    output logic             serial_mode,
    // direct mode and attention
    input  wire logic        direct_mode,
    input  wire logic        subcarrier,
    output logic             mod_in,
    output logic             rx_enable,
    input  wire logic        irq_req
);
    // core state
    rhp_pkg::rhp_frame_t st_reg, st_next;
    logic [10:0] sy, q_reg;
    logic        mode_reg, mode_next, act_reg, act_next;
    logic        arm_reg, arm_next, skip_reg, skip_next;
    logic        rw_reg, rw_next, cont_reg, cont_next;
    logic [4:0]  adr_reg, adr_next;
    logic [7:0]  rd_reg, rd_next;
    logic [4:0]  ra_reg, ra_next, cc_reg, cc_next;
    logic [7:0]  wd_reg, wd_next;
    logic        we_reg, we_next, re_reg, re_next;
    logic        cv_reg, cv_next, err_reg, err_next;
    logic        mod_reg, mod_next, rxe_reg, rxe_next;
    logic        irq_reg, irq_next, sc_reg, sc_next;
    logic        drv_reg, drv_next;
    // link-clock state
    logic        ser_rst_n;
    logic [7:0]  rx_sh_reg, rx_sh_next, sw_reg, sw_next;
    logic [2:0]  rx_cnt_reg, rx_cnt_next;
    logic        tgl_reg, tgl_next;
    logic [7:0]  tx_sh_reg, tx_sh_next;
    logic [2:0]  tx_cnt_reg, tx_cnt_next;
    // decoded pin events
    logic [7:0]  pins_s, pins_q, word;
    logic        lclk_s, lclk_q, low_zero, par, ser;
    logic        b7r, b7f, start, stop_s, stop_b, ser_end, clk_fall, word_ev;

    // serial shifter runs on the host's clock; held in reset while select is high
    assign ser_rst_n = resetn & mode_reg & act_reg & ~link.pins[rhp_pkg::P_SS];

    always_comb
    begin
        rx_sh_next  = {rx_sh_reg[6:0], link.pins[rhp_pkg::P_MOSI]};
        rx_cnt_next = rx_cnt_reg + 3'h1;
        sw_next     = sw_reg;
        tgl_next    = tgl_reg;
        if (rx_cnt_reg == 3'h7)
        begin
            sw_next  = rx_sh_next;
            tgl_next = ~tgl_reg;
        end
        // read data goes out on the rising edge, msb first
        tx_cnt_next = tx_cnt_reg + 3'h1;
        tx_sh_next  = (tx_cnt_reg == 3'h0) ? rd_reg : {tx_sh_reg[6:0], 1'b0};
    end

    // host data sampled on the falling edge
    always_ff @(negedge link.link_clk or negedge ser_rst_n)
    begin
        if (!ser_rst_n)
        begin
            rx_sh_reg  <= 8'h00;
            rx_cnt_reg <= 3'h0;
        end
        else
        begin
            rx_sh_reg  <= rx_sh_next;
            rx_cnt_reg <= rx_cnt_next;
        end
    end

    // word and toggle survive select so no false word is signalled
    always_ff @(negedge link.link_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sw_reg  <= 8'h00;
            tgl_reg <= 1'b0;
        end
        else
        begin
            sw_reg  <= sw_next;
            tgl_reg <= tgl_next;
        end
    end

    always_ff @(posedge link.link_clk or negedge ser_rst_n)
    begin
        if (!ser_rst_n)
        begin
            tx_sh_reg  <= 8'h00;
            tx_cnt_reg <= 3'h0;
        end
        else
        begin
            tx_sh_reg  <= tx_sh_next;
            tx_cnt_reg <= tx_cnt_next;
        end
    end

    rhp_sync #(
        .W     (rhp_pkg::SYNC_W)
    ) u_sync (
        .clk   (core_clk),
        .rst_n (resetn),
        .ce    (ce),
        .d     ({tgl_reg, link.en, link.link_clk, link.pins}),
        .q     (sy)
    );

    always_comb
    begin
        pins_s   = sy[7:0];
        pins_q   = q_reg[7:0];
        lclk_s   = sy[8];
        lclk_q   = q_reg[8];
        low_zero = (pins_s[6:0] == 7'h00);
        par      = act_reg & ~mode_reg;
        ser      = act_reg & mode_reg;
        b7r      = pins_s[7] & ~pins_q[7];
        b7f      = ~pins_s[7] & pins_q[7];
        start    = (par & b7r & lclk_s & lclk_q & low_zero)
                 | (ser & ~pins_s[rhp_pkg::P_SS] & pins_q[rhp_pkg::P_SS]);
        stop_s   = par & b7f & lclk_s & lclk_q & low_zero;
        stop_b   = par & b7f & arm_reg & ~lclk_s & ~lclk_q & low_zero;
        ser_end  = ser & pins_s[rhp_pkg::P_SS] & ~pins_q[rhp_pkg::P_SS];
        clk_fall = par & lclk_q & ~lclk_s;
        word_ev  = (clk_fall & ~skip_reg) | (ser & (sy[10] ^ q_reg[10]));
        word     = mode_reg ? sw_reg : pins_s;

        st_next   = st_reg;
        mode_next = mode_reg;
        act_next  = act_reg;
        rw_next   = rw_reg;
        cont_next = cont_reg;
        adr_next  = adr_reg;
        ra_next   = ra_reg;
        wd_next   = wd_reg;
        cc_next   = cc_reg;
        we_next   = 1'b0;
        re_next   = 1'b0;
        cv_next   = 1'b0;
        err_next  = 1'b0;
        rd_next   = re_reg ? reg_rdata : rd_reg;
        // rise then fall with clock low arms and completes the burst stop
        arm_next  = (~par | lclk_s | lclk_q | ~low_zero) ? 1'b0 : (b7r | arm_reg);
        skip_next = start ? 1'b1 : (clk_fall ? 1'b0 : skip_reg);

        if (start)
            st_next = rhp_pkg::FR_HEAD;
        else if (stop_s | stop_b | ser_end)
        begin
            st_next  = rhp_pkg::FR_IDLE;
            err_next = st_reg == rhp_pkg::FR_DATA && cont_reg ? stop_s : stop_b;
        end
        else if (word_ev)
        begin
            unique case (st_reg)
                rhp_pkg::FR_IDLE:
                    st_next = rhp_pkg::FR_IDLE;
                rhp_pkg::FR_HEAD:
                begin
                    if (word[rhp_pkg::CMD_BIT])
                    begin
                        cc_next = word[4:0];
                        cv_next = 1'b1;
                    end
                    else
                    begin
                        rw_next   = word[rhp_pkg::RW_BIT];
                        cont_next = word[rhp_pkg::CONT_BIT];
                        adr_next  = word[4:0];
                        ra_next   = word[4:0];
                        re_next   = word[rhp_pkg::RW_BIT];
                        st_next   = rhp_pkg::FR_DATA;
                    end
                end
                rhp_pkg::FR_DATA:
                begin
                    if (!rw_reg)
                    begin
                        ra_next = adr_reg;
                        wd_next = word;
                        we_next = 1'b1;
                    end
                    if (cont_reg)
                    begin
                        adr_next = adr_reg + 5'h01;
                        // only a read fetches ahead; a write must land at its own address
                        if (rw_reg)
                            ra_next = adr_reg + 5'h01;
                        re_next  = rw_reg;
                    end
                    else
                        st_next = rhp_pkg::FR_HEAD;
                end
            endcase
        end

        // type latched only at enable rise and kept; port made inactive while enable is low
        if (sy[9] & ~q_reg[9])
        begin
            mode_next = pins_s[rhp_pkg::P_STRAP_HI] & ~pins_s[rhp_pkg::P_STRAP_LO]
                      & pins_s[rhp_pkg::P_SS];
            act_next  = 1'b1;
            st_next   = rhp_pkg::FR_IDLE;
        end
        else if (!sy[9])
        begin
            act_next = 1'b0;
            st_next  = rhp_pkg::FR_IDLE;
        end

        drv_next = par & ~direct_mode & (st_reg == rhp_pkg::FR_DATA) & rw_reg & lclk_s;
        mod_next = direct_mode & act_reg & pins_s[rhp_pkg::P_MOD];
        rxe_next = direct_mode & act_reg & pins_s[rhp_pkg::P_RXEN];
        sc_next  = subcarrier;
        irq_next = irq_req;
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            q_reg    <= 11'h000;
            st_reg   <= rhp_pkg::FR_IDLE;
            mode_reg <= 1'b0;
            act_reg  <= 1'b0;
            arm_reg  <= 1'b0;
            skip_reg <= 1'b0;
            rw_reg   <= 1'b0;
            cont_reg <= 1'b0;
            adr_reg  <= 5'h00;
            rd_reg   <= 8'h00;
            ra_reg   <= 5'h00;
            wd_reg   <= 8'h00;
            cc_reg   <= 5'h00;
            we_reg   <= 1'b0;
            re_reg   <= 1'b0;
            cv_reg   <= 1'b0;
            err_reg  <= 1'b0;
            drv_reg  <= 1'b0;
            mod_reg  <= 1'b0;
            rxe_reg  <= 1'b0;
            sc_reg   <= 1'b0;
            irq_reg  <= 1'b0;
        end
        else if (ce)
        begin
            q_reg    <= sy;
            st_reg   <= st_next;
            mode_reg <= mode_next;
            act_reg  <= act_next;
            arm_reg  <= arm_next;
            skip_reg <= skip_next;
            rw_reg   <= rw_next;
            cont_reg <= cont_next;
            adr_reg  <= adr_next;
            rd_reg   <= rd_next;
            ra_reg   <= ra_next;
            wd_reg   <= wd_next;
            cc_reg   <= cc_next;
            we_reg   <= we_next;
            re_reg   <= re_next;
            cv_reg   <= cv_next;
            err_reg  <= err_next;
            drv_reg  <= drv_next;
            mod_reg  <= mod_next;
            rxe_reg  <= rxe_next;
            sc_reg   <= sc_next;
            irq_reg  <= irq_next;
        end
    end

    // pin drive: direct subcarrier, serial miso, or parallel read data
    always_comb
    begin
        if (direct_mode && act_reg)
        begin
            link.dev_o  = {1'b0, sc_reg, sc_reg, 5'h00};
            link.dev_oe = rhp_pkg::SUB_OE;
        end
        else if (ser && !pins_s[rhp_pkg::P_SS])
        begin
            link.dev_o  = {1'b0, tx_sh_reg[7], 6'h00};
            link.dev_oe = rhp_pkg::MISO_OE;
        end
        else
        begin
            link.dev_o  = rd_reg;
            link.dev_oe = drv_reg ? rhp_pkg::PIN_ALL : rhp_pkg::PIN_NONE;
        end
    end

    assign link.irq    = irq_reg;
    assign reg_addr    = ra_reg;
    assign reg_wdata   = wd_reg;
    assign reg_we      = we_reg;
    assign reg_re      = re_reg;
    assign cmd_code    = cc_reg;
    assign cmd_valid   = cv_reg;
    assign frame_err   = err_reg;
    assign serial_mode = mode_reg;
    assign mod_in      = mod_reg;
    assign rx_enable   = rxe_reg;
endmodule : rhp_reader_end

// ==== src/rhp_host_end.sv ====
// host end: drives enable, straps, link clock and pin sequences for each operation
module rhp_host_end #(
    parameter int HALF_CYC = rhp_pkg::HALF_CYC
) (
    // core clock domain
    input  wire logic            core_clk,
    input  wire logic            resetn,
    input  wire logic            ce,
    // link to the reader
    rhp_if.host                  link,
    // control
    input  wire logic            ser_mode,
    input  wire logic            en_req,
    // operation request
    input  wire logic            cmd_valid,
    output logic                 cmd_ready,
    input  wire rhp_pkg::rhp_op_t cmd_op,
    input  wire logic [7:0]      cmd_word,
    // read answer
    output logic                 rsp_valid,
    output logic [7:0]           rsp_word,
    output logic                 irq
);
    rhp_pkg::rhp_hstate_t st_reg, st_next;
    rhp_pkg::rhp_op_t     op_reg, op_next;
    logic [15:0] tick_reg, tick_next;
    logic [4:0]  step_reg, step_next;
    logic [7:0]  w_reg, w_next, rx_reg, rx_next, d_reg, d_next, oe_reg, oe_next;
    logic [7:0]  pins_s, t_d, t_oe;
    logic        clk_reg, clk_next, en_reg, en_next, rv_reg, rv_next;
    logic        t_clk, t_last, t_smp, tick;

    rhp_sync #(
        .W     (8)
    ) u_sync (
        .clk   (core_clk),
        .rst_n (resetn),
        .ce    (ce),
        .d     (link.pins),
        .q     (pins_s)
    );

    // pin pattern of the current step
    always_comb
    begin
        t_clk  = 1'b0;
        t_d    = rhp_pkg::PIN_NONE;
        t_oe   = rhp_pkg::PIN_ALL;
        t_last = 1'b0;
        t_smp  = 1'b0;
        if (ser_mode)
        begin
            t_oe = rhp_pkg::SER_OE;
            unique case (op_reg)
                rhp_pkg::OP_WRITE, rhp_pkg::OP_READ:
                begin
                    t_clk  = ~step_reg[0];
                    t_d    = {w_reg[~step_reg[3:1]], 7'h02};
                    t_smp  = step_reg[0];
                    t_last = step_reg == 5'h0F;
                end
                default:
                begin
                    t_d    = (op_reg == rhp_pkg::OP_START) == (step_reg == 5'h00)
                           ? rhp_pkg::SER_STRAP : 8'h02;
                    t_last = step_reg == 5'h01;
                end
            endcase
        end
        else
        begin
            unique case (op_reg)
                rhp_pkg::OP_START:
                begin
                    t_clk  = step_reg == 5'h01 || step_reg == 5'h02;
                    t_d    = step_reg[1] ? rhp_pkg::PAR_MARK : rhp_pkg::PIN_NONE;
                    t_last = step_reg == 5'h03;
                end
                rhp_pkg::OP_WRITE:
                begin
                    t_clk  = step_reg == 5'h01;
                    t_d    = w_reg;
                    t_last = step_reg == 5'h02;
                end
                rhp_pkg::OP_READ:
                begin
                    t_clk  = step_reg == 5'h01 || step_reg == 5'h02;
                    t_oe   = rhp_pkg::PIN_NONE;
                    t_smp  = step_reg == 5'h02;
                    t_last = step_reg == 5'h03;
                end
                rhp_pkg::OP_STOP_SGL:
                begin
                    t_clk  = step_reg != 5'h00;
                    t_d    = step_reg[1] ? rhp_pkg::PIN_NONE : rhp_pkg::PAR_MARK;
                    t_last = step_reg == 5'h02;
                end
                default:
                begin
                    t_d    = step_reg == 5'h01 ? rhp_pkg::PAR_MARK : rhp_pkg::PIN_NONE;
                    t_last = step_reg == 5'h02;
                end
            endcase
        end
    end

    always_comb
    begin
        st_next   = st_reg;
        op_next   = op_reg;
        w_next    = w_reg;
        rx_next   = rx_reg;
        d_next    = d_reg;
        oe_next   = oe_reg;
        clk_next  = clk_reg;
        rv_next   = 1'b0;
        en_next   = en_req;
        tick      = tick_reg == 16'(HALF_CYC - 1);
        tick_next = (st_reg == rhp_pkg::HS_RUN && !tick) ? tick_reg + 16'h0001 : 16'h0000;
        step_next = step_reg;
        if (st_reg == rhp_pkg::HS_IDLE)
        begin
            if (!en_reg)
            begin
                // straps must stand before enable rises; type follows ser_mode
                d_next   = ser_mode ? rhp_pkg::SER_STRAP : rhp_pkg::PIN_NONE;
                oe_next  = ser_mode ? rhp_pkg::SER_OE : rhp_pkg::PIN_ALL;
                clk_next = 1'b0;
            end
            else if (cmd_valid)
            begin
                st_next   = rhp_pkg::HS_RUN;
                op_next   = cmd_op;
                w_next    = (cmd_op == rhp_pkg::OP_READ) ? rhp_pkg::PIN_NONE : cmd_word;
                step_next = 5'h00;
            end
        end
        else if (tick)
        begin
            d_next    = t_d;
            oe_next   = t_oe;
            clk_next  = t_clk;
            step_next = step_reg + 5'h01;
            if (t_smp)
                rx_next = ser_mode ? {rx_reg[6:0], pins_s[rhp_pkg::P_MISO]} : pins_s;
            if (t_last)
            begin
                st_next = rhp_pkg::HS_IDLE;
                rv_next = op_reg == rhp_pkg::OP_READ;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_reg   <= rhp_pkg::HS_IDLE;
            op_reg   <= rhp_pkg::OP_START;
            tick_reg <= 16'h0000;
            step_reg <= 5'h00;
            w_reg    <= 8'h00;
            rx_reg   <= 8'h00;
            d_reg    <= 8'h00;
            oe_reg   <= 8'hFF;
            clk_reg  <= 1'b0;
            en_reg   <= 1'b0;
            rv_reg   <= 1'b0;
        end
        else if (ce)
        begin
            st_reg   <= st_next;
            op_reg   <= op_next;
            tick_reg <= tick_next;
            step_reg <= step_next;
            w_reg    <= w_next;
            rx_reg   <= rx_next;
            d_reg    <= d_next;
            oe_reg   <= oe_next;
            clk_reg  <= clk_next;
            en_reg   <= en_next;
            rv_reg   <= rv_next;
        end
    end

    assign cmd_ready     = (st_reg == rhp_pkg::HS_IDLE) & en_reg;
    assign link.link_clk = clk_reg;
    assign link.en       = en_reg;
    assign link.host_o   = d_reg;
    assign link.host_oe  = oe_reg;
    assign rsp_valid     = rv_reg;
    assign rsp_word      = rx_reg;
    assign irq           = link.irq;
endmodule : rhp_host_end

// ==== dv/rhp_props.sv ====
// assertions on the link between the host end and the reader end
module rhp_props (
    // clock and reset
    input wire logic       core_clk,
    input wire logic       resetn,
    // link
    input wire logic       link_clk,
    input wire logic       en,
    input wire logic [7:0] host_o,
    input wire logic [7:0] host_oe,
    input wire logic [7:0] dev_oe,
    input wire logic [7:0] pins
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    logic ser;
    assign ser = en && host_oe == rhp_pkg::SER_OE;
    chk_no_fight: assert property (not (((dev_oe & host_oe) != 8'h00) [*6]))
        else $error("both ends drive one pin");
    chk_quiet_off: assert property (!en [*6] |-> dev_oe == 8'h00)
        else $error("reader drives while disabled");
    chk_strap_rise: assert property ($rose(en) |-> pins inside {8'h00, 8'h12})
        else $error("bad pins at enable rise");
    chk_type_held: assert property (en && $past(ser) |-> ser)
        else $error("type changed while enabled");
    chk_ser_pins: assert property (ser |-> (dev_oe & ~rhp_pkg::MISO_OE) == 8'h00)
        else $error("reader drives a non-miso pin");
    chk_mosi_hold: assert property (ser && link_clk && $past(link_clk) |-> $stable(pins[7]))
        else $error("mosi moved while clock high");
    chk_par_sep: assert property (en && !ser && $changed(link_clk) |-> $stable(host_o))
        else $error("data and clock moved together");
    chk_ss_idle: assert property (ser && pins[4] && $past(pins[4]) |-> $stable(link_clk))
        else $error("clock ran while deselected");
    cover property ($rose(en) && pins == rhp_pkg::SER_STRAP);
    cover property (ser && dev_oe[6]);
    cover property (en && !ser && dev_oe == 8'hFF);
endmodule : rhp_props

// ==== dv/reader_host_command_port_tb_top.sv ====
// self-checking bench joining the host end and the reader end
module reader_host_command_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic             core_clk, resetn, ser_mode, en_req, cmd_valid, cmd_ready, rsp_valid;
    logic             irq, reg_we, dev_cmd, frame_err, serial_mode, irq_req;
    logic [4:0]       reg_addr, cmd_code, wa, cc;
    logic [7:0]       reg_wdata, reg_rdata, cmd_word, rsp_word, wd;
    logic [15:0]      seed;
    rhp_pkg::rhp_op_t cmd_op;
    int               failures = 0, total_checks = 0, nwe = 0, nfe = 0, nrv = 0;
    rhp_if link_if();
    rhp_host_end i_rhp_host_end (.core_clk(core_clk), .resetn(resetn), .ce(1'h1),
        .link(link_if.host), .ser_mode(ser_mode), .en_req(en_req), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_word(cmd_word), .rsp_valid(rsp_valid),
        .rsp_word(rsp_word), .irq(irq));
    rhp_reader_end i_rhp_reader_end (.core_clk(core_clk), .resetn(resetn), .ce(1'h1),
        .link(link_if.dev), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
        .reg_re(), .reg_rdata(reg_rdata), .cmd_code(cmd_code), .cmd_valid(dev_cmd),
        .frame_err(frame_err), .serial_mode(serial_mode), .direct_mode(1'h0),
        .subcarrier(1'h0), .mod_in(), .rx_enable(), .irq_req(irq_req));
    rhp_props u_props (.core_clk(core_clk), .resetn(resetn), .link_clk(link_if.link_clk),
        .en(link_if.en), .host_o(link_if.host_o), .host_oe(link_if.host_oe),
        .dev_oe(link_if.dev_oe), .pins(link_if.pins));
    function automatic logic [7:0] exp_rd(input logic [4:0] a);
        return {3'h5, a};
    endfunction : exp_rd
    function automatic logic [15:0] nx(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nx
    assign reg_rdata = exp_rd(reg_addr);
    always @(posedge core_clk)
    begin
        if (reg_we === 1'h1)
        begin
            wa <= reg_addr;
            wd <= reg_wdata;
            nwe <= nwe + 1;
        end
        if (dev_cmd === 1'h1)
            cc <= cmd_code;
        if (frame_err === 1'h1)
            nfe <= nfe + 1;
        if (rsp_valid === 1'h1)
            nrv <= nrv + 1;
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e)
        begin
            failures++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic settle();
        int n;
        n = 0;
        while (cmd_ready !== 1'h1 && n < 5000)
        begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 5000)
        begin
            failures++;
            $display("[FAIL] %0t host end never ready", $time);
        end
    endtask : settle
    task automatic op(input rhp_pkg::rhp_op_t o, input logic [7:0] w);
        settle();
        cmd_op = o;
        cmd_word = w;
        cmd_valid = 1'h1;
        @(negedge core_clk);
        cmd_valid = 1'h0;
    endtask : op
    task automatic results();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results
    initial
    begin
        core_clk = 1'h0;
        forever #5 core_clk = ~core_clk;
    end
    initial
    begin
        #100000;
        failures++;
        results();
    end
    initial
    begin
        resetn = 1'h0;
        {ser_mode, en_req, cmd_valid, irq_req, cmd_word} = 12'h000;
        cmd_op = rhp_pkg::OP_START;
        seed = 16'h34AE;
        repeat (5) @(negedge core_clk);
        resetn = 1'h1;
        for (int m = 0; m < 2; m++)
        begin
            logic [4:0] a;
            logic [7:0] d1, d2;
            int b, f;
            ser_mode = m[0];
            @(negedge core_clk);
            en_req = 1'h1;
            repeat (10) @(negedge core_clk);
            seed = nx(seed);
            a = m ? seed[4:0] : 5'h1F;
            d1 = seed[15:8];
            seed = nx(seed);
            d2 = seed[7:0];
            b = nwe;
            op(rhp_pkg::OP_START, 8'h00);
            op(rhp_pkg::OP_WRITE, {3'h1, a});
            op(rhp_pkg::OP_WRITE, d1);
            op(rhp_pkg::OP_WRITE, d2);
            op(rhp_pkg::OP_STOP_BURST, 8'h00);
            settle();
            repeat (10) @(negedge core_clk);
            chk({3'h0, wa}, {3'h0, a + 5'h01});
            chk(wd, d2);
            chk(8'(nwe - b), 8'h02);
            op(rhp_pkg::OP_START, 8'h00);
            op(rhp_pkg::OP_WRITE, {3'h0, a ^ 5'h0A});
            op(rhp_pkg::OP_WRITE, d1);
            op(rhp_pkg::OP_WRITE, {3'h4, a});
            op(rhp_pkg::OP_WRITE, {3'h2, a});
            op(rhp_pkg::OP_READ, 8'h00);
            op(rhp_pkg::OP_STOP_SGL, 8'h00);
            settle();
            repeat (10) @(negedge core_clk);
            chk({3'h0, wa}, {3'h0, a ^ 5'h0A});
            chk(wd, d1);
            chk(8'(nwe - b), 8'h03);
            chk({3'h0, cc}, {3'h0, a});
            chk(rsp_word, exp_rd(a));
            chk(8'(nrv), 8'(m + 1));
            f = nfe;
            op(rhp_pkg::OP_START, 8'h00);
            op(rhp_pkg::OP_WRITE, {3'h1, a});
            op(rhp_pkg::OP_WRITE, d1);
            op(rhp_pkg::OP_STOP_SGL, 8'h00);
            settle();
            repeat (10) @(negedge core_clk);
            // serial stop is the select rise alone, so no wrong-kind stop exists there
            chk(8'(nfe - f), m ? 8'h00 : 8'h01);
            chk({7'h00, serial_mode}, {7'h00, m[0]});
            irq_req = 1'h1;
            repeat (4) @(negedge core_clk);
            chk({7'h00, irq}, 8'h01);
            irq_req = 1'h0;
            en_req = 1'h0;
            repeat (10) @(negedge core_clk);
            $display("test %0d done", m);
        end
        results();
    end
endmodule : reader_host_command_port_tb_top
